// File: ssc_clkmon.sv
`timescale 1ns/100ps
module ssc_clkmon
  import ssc_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOSS_CYC = CLK_LOSS_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic pwm_clk_s,
  output logic      lost
);

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] cnt;
    logic             lost;
  } ssc_cm_s;

  ssc_cm_s st_q;
  ssc_cm_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = pwm_clk_s;
    if (!enable || (pwm_clk_s != st_q.prev)) begin
      st_d.cnt  = '0;
      st_d.lost = 1'b0;
    end else if (st_q.cnt == LOSS_CYC - 1'b1) begin
      st_d.lost = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lost = st_q.lost;

endmodule : ssc_clkmon

// File: ssc_front_end.sv
`timescale 1ns/100ps
// Functional notes
// - Both sense select bits clear: sense output goes high impedance.
// - Sense output disabled while any overcurrent window is active.
// - No sensing in fail-safe, nor in normal mode without logic supply.
// - Track-and-hold: while channel off, present value held before turn-off.
// - Sense-ready pulled low once settled, released at each turn-off.
// - Direct input low turns channel off, high turns it on.
// - Rising edge on either direct input wakes the device from sleep.
// - Load-type input low selects bulb profile, high selects motor profile.
// - Any fault drives the open-drain fault flag low.
// - Each fault has its own bit; reading the register clears it.
// - External PWM clock monitored; loss raises a clock-fail fault.
// - All serial registers held at reset value while reset input low; the code keeps the latched fault bits.
// - With reset low, sleep a fixed delay after last direct input falls.
// - Rising reset input wakes device and starts the watchdog.
// - First word bit must toggle within timeout, else fail-safe.
// - Transfers only with chip select low; otherwise ignore and tristate.
// - Chip select rise copies shift register into addressed register.
// - Chip select fall loads output shifter from previously selected register.
// - Input sampled on serial clock fall, output shifted on rise.
// - Sixteen-bit words, MSB first, address in bits 12 to 9.
// - After wake-up all registers return to defaults, normal mode entered; the code keeps the latched fault bits.
module ssc_front_end
  import ssc_pkg::*;
#(
  parameter logic [CNT_W-1:0] ALIVE_CYC  = ALIVE_TIMEOUT_CYC,
  parameter logic [CNT_W-1:0] SLEEP_CYC  = SLEEP_DLY_CYC,
  parameter logic [CNT_W-1:0] LOSS_CYC   = CLK_LOSS_CYC,
  parameter logic [7:0]       SETTLE_CYC = SENSE_SETTLE_CYC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               sclk,
  input  wire logic               chip_sel_n,
  input  wire logic               si,
  output logic                    so_out,
  output logic                    so_oe_n,
  input  wire logic               reset_n_in,
  input  wire logic [1:0]         din,
  input  wire logic [1:0]         load_type_sel,
  input  wire logic               vdd_ok,
  input  wire logic               pwm_clk,
  input  wire ssc_flt_s [1:0]     chan_flt,
  input  wire logic               ov_evt,
  input  wire logic               uv_evt,
  input  wire logic [1:0]         oc_window,
  input  wire logic [SENSE_W-1:0] sense_in,
  output logic [SENSE_W-1:0]      sense_out,
  output logic                    sense_out_oe_n,
  output logic                    sense_rdy_n_out,
  output logic                    sense_rdy_n_oe_n,
  output logic                    fault_flag_n_out,
  output logic                    fault_flag_n_oe_n,
  output logic [1:0]              chan_on,
  output logic [1:0]              load_motor,
  output logic                    asleep,
  output logic                    failsafe
);

  typedef struct packed {
    ssc_mode_e          mode;
    logic [15:0]        sh_in;
    logic [15:0]        sh_out;
    logic [4:0]         bits;
    logic [2:0]         rd_ptr;
    logic [2:0]         rd_cur;
    logic               so;
    logic [15:0]        global_config_reg;
    logic [15:0]        ctl0;
    logic [15:0]        ctl1;
    logic [1:0][3:0]    flt;
    logic [1:0][1:0]    diag;
    logic [2:0]         gstat;
    logic               sclk_p;
    logic               cs_p;
    logic               rst_p;
    logic [1:0]         din_p;
    logic               alive;
    logic [CNT_W-1:0]   wd_cnt;
    logic [CNT_W-1:0]   sl_cnt;
    logic [1:0]         chan;
    logic [SENSE_W-1:0] hold;
    logic [7:0]         settle;
    logic               rdy;
  } ssc_fe_s;

  ssc_fe_s st_q;
  ssc_fe_s st_d;

  logic [9:0] sync_q;
  logic       sclk_s;
  logic       cs_s;
  logic       si_s;
  logic       rst_s;
  logic [1:0] din_s;
  logic       vdd_s;
  logic       pwm_s;
  logic       clk_lost;

  ssc_sync #(.W(10)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({pwm_clk, vdd_ok, load_type_sel, din, reset_n_in, si, chip_sel_n, sclk}),
    .sync_out (sync_q)
  );

  assign sclk_s     = sync_q[0];
  assign cs_s       = sync_q[1];
  assign si_s       = sync_q[2];
  assign rst_s      = sync_q[3];
  assign din_s      = sync_q[5:4];
  assign load_motor = sync_q[7:6];
  assign vdd_s      = sync_q[8];
  assign pwm_s      = sync_q[9];

  ssc_clkmon #(.LOSS_CYC(LOSS_CYC)) u_clkmon (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .enable    (st_q.global_config_reg[GCR_EXT_CLK] && (st_q.mode != SSC_SLEEP)),
    .pwm_clk_s (pwm_s),
    .lost      (clk_lost)
  );

  function automatic logic [15:0] rd_word(input logic [2:0] idx, input ssc_fe_s s);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      RD_STAT:  w = {8'h00, s.chan, s.mode == SSC_NORMAL, s.mode == SSC_FAILSAFE,
                     1'b0, s.gstat};
      RD_FLT0:  w = {12'h000, s.flt[0]};
      RD_FLT1:  w = {12'h000, s.flt[1]};
      RD_DIAG0: w = {14'h0000, s.diag[0]};
      RD_DIAG1: w = {14'h0000, s.diag[1]};
      RD_GCR:   w = s.global_config_reg;
      RD_CTL0:  w = s.ctl0;
      RD_CTL1:  w = s.ctl1;
      default:  w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       word_done;
  logic [3:0] word_addr;
  logic       rst_rise;
  logic       din_rise;
  logic       sense_en;
  logic       sel_ch;
  logic       any_fault;
  logic       regs_clear;

  assign sclk_rise = !cs_s && sclk_s && !st_q.sclk_p;
  assign sclk_fall = !cs_s && !sclk_s && st_q.sclk_p;
  assign cs_fall   = st_q.cs_p && !cs_s;
  assign cs_rise   = !st_q.cs_p && cs_s;
  assign word_done = cs_rise && (st_q.bits == WORD_BITS);
  assign word_addr = st_q.sh_in[ADDR_MSB:ADDR_LSB];
  assign rst_rise  = rst_s && !st_q.rst_p;
  assign din_rise  = |(din_s & ~st_q.din_p);
  assign sel_ch    = st_q.global_config_reg[GCR_SENSE_B];
  assign sense_en  = (st_q.global_config_reg[GCR_SENSE_A] || st_q.global_config_reg[GCR_SENSE_B])
                     && !(|oc_window)
                     && (st_q.mode == SSC_NORMAL) && vdd_s;
  assign any_fault = (|st_q.flt) || (|st_q.diag) || (|st_q.gstat);
  // Registers return to defaults on reset low and on every wake-up
  assign regs_clear = !rst_s
                      || ((st_q.mode == SSC_SLEEP) && (din_rise || rst_rise));

  always_comb begin
    logic [3:0] clr_f0;
    logic [3:0] clr_f1;
    logic [1:0] clr_d0;
    logic [1:0] clr_d1;
    logic [2:0] clr_g;
    clr_f0 = 4'h0;
    clr_f1 = 4'h0;
    clr_d0 = 2'h0;
    clr_d1 = 2'h0;
    clr_g  = 3'h0;
    st_d        = st_q;
    st_d.sclk_p = sclk_s;
    st_d.cs_p   = cs_s;
    st_d.rst_p  = rst_s;
    st_d.din_p  = din_s;

    // Serial shifting
    if (cs_fall) begin
      st_d.sh_out = rd_word(st_q.rd_ptr, st_q);
      st_d.so     = st_d.sh_out[WORD_W-1];
      st_d.rd_cur = st_q.rd_ptr;
      st_d.bits   = 5'h00;
    end else if (sclk_fall) begin
      st_d.sh_in = {st_q.sh_in[WORD_W-2:0], si_s};
      if (st_q.bits != 5'h1F) begin
        st_d.bits = st_q.bits + 5'h01;
      end
    end else if (sclk_rise && (st_q.bits != 5'h00)) begin
      st_d.sh_out = {st_q.sh_out[WORD_W-2:0], 1'b0};
      st_d.so     = st_q.sh_out[WORD_W-2];
    end

    // Word latch and clear-on-read of what was shifted out
    if (word_done) begin
      st_d.rd_ptr = word_addr[2:0];
      case (word_addr)
        ADDR_GCR:  st_d.global_config_reg  = st_q.sh_in;
        ADDR_CTL0: st_d.ctl0 = st_q.sh_in;
        ADDR_CTL1: st_d.ctl1 = st_q.sh_in;
        default:   st_d.global_config_reg  = st_q.global_config_reg;
      endcase
      case (st_q.rd_cur)
        RD_STAT:  clr_g  = st_q.gstat;
        RD_FLT0:  clr_f0 = st_q.flt[0];
        RD_FLT1:  clr_f1 = st_q.flt[1];
        RD_DIAG0: clr_d0 = st_q.diag[0];
        RD_DIAG1: clr_d1 = st_q.diag[1];
        default:  clr_g  = 3'h0;
      endcase
    end

    // Sticky fault bits, a new event wins over the read clear
    for (int c = 0; c < 2; c++) begin
      st_d.flt[c]  = st_q.flt[c] & ~((c == 0) ? clr_f0 : clr_f1);
      st_d.diag[c] = st_q.diag[c] & ~((c == 0) ? clr_d0 : clr_d1);
      st_d.flt[c]  = st_d.flt[c] | {chan_flt[c].oc, chan_flt[c].ot,
                                    chan_flt[c].short_vpwr, chan_flt[c].severe_sc};
      st_d.diag[c] = st_d.diag[c] | {chan_flt[c].open_load_on, chan_flt[c].open_load_off};
    end
    st_d.gstat = (st_q.gstat & ~clr_g) | {clk_lost, uv_evt, ov_evt};

    // Operating mode
    case (st_q.mode)
      SSC_SLEEP: begin
        st_d.wd_cnt = '0;
        st_d.sl_cnt = '0;
        if (din_rise || rst_rise) begin
          st_d.mode = SSC_NORMAL;
        end
      end
      SSC_NORMAL, SSC_FAILSAFE: begin
        if (!rst_s && (din_s == 2'b00)) begin
          if (st_q.sl_cnt == SLEEP_CYC - 1'b1) begin
            st_d.mode = SSC_SLEEP;
          end else begin
            st_d.sl_cnt = st_q.sl_cnt + 1'b1;
          end
        end else begin
          st_d.sl_cnt = '0;
        end
        if (!rst_s || rst_rise) begin
          st_d.wd_cnt = '0;
          st_d.alive  = 1'b0;
          if (rst_rise) begin
            st_d.mode = SSC_NORMAL;
          end
        end else if (st_q.mode == SSC_NORMAL) begin
          if (word_done && (st_q.sh_in[ALIVE_BIT] != st_q.alive)) begin
            st_d.alive  = st_q.sh_in[ALIVE_BIT];
            st_d.wd_cnt = '0;
          end else if (st_q.wd_cnt == ALIVE_CYC - 1'b1) begin
            st_d.mode = SSC_FAILSAFE;
          end else begin
            st_d.wd_cnt = st_q.wd_cnt + 1'b1;
          end
        end
      end
      default: begin
        st_d.mode = SSC_SLEEP;
      end
    endcase

    if (regs_clear) begin
      st_d.global_config_reg    = GCR_RST;
      st_d.ctl0   = CTL_RST;
      st_d.ctl1   = CTL_RST;
      st_d.rd_ptr = RD_STAT;
    end

    // Channel drive
    case (st_q.mode)
      SSC_NORMAL: begin
        st_d.chan[0] = st_q.ctl0[CTL_DIR_DIS] ? st_q.ctl0[CTL_ON] : din_s[0];
        st_d.chan[1] = st_q.ctl1[CTL_DIR_DIS] ? st_q.ctl1[CTL_ON] : din_s[1];
      end
      SSC_FAILSAFE: st_d.chan = din_s;
      default:      st_d.chan = 2'b00;
    endcase

    // Sense tracking, hold and ready
    if (st_q.chan[sel_ch] || !st_q.global_config_reg[GCR_TH_EN]) begin
      st_d.hold = sense_in;
    end
    if (!sense_en || (st_q.chan[sel_ch] && !st_d.chan[sel_ch])) begin
      st_d.settle = 8'h00;
      st_d.rdy    = 1'b0;
    end else if (st_q.chan[sel_ch]) begin
      if (st_q.settle == SETTLE_CYC - 8'h01) begin
        st_d.rdy = 1'b1;
      end else begin
        st_d.settle = st_q.settle + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q      <= '0;
      st_q.mode <= SSC_SLEEP;
      st_q.cs_p <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign so_out            = st_q.so;
  assign so_oe_n           = cs_s;
  assign sense_out         = st_q.hold;
  assign sense_out_oe_n    = !sense_en;
  assign sense_rdy_n_out   = 1'b0;
  assign sense_rdy_n_oe_n  = !st_q.rdy;
  assign fault_flag_n_out  = 1'b0;
  assign fault_flag_n_oe_n = !any_fault;
  assign chan_on           = st_q.chan;
  assign asleep            = st_q.mode == SSC_SLEEP;
  assign failsafe          = st_q.mode == SSC_FAILSAFE;

  a_sense_tristate: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!st_q.global_config_reg[GCR_SENSE_A] && !st_q.global_config_reg[GCR_SENSE_B]) |-> sense_out_oe_n)
    else $error("sense output driven with both select bits clear");

  a_sense_oc_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (|oc_window) |-> (sense_out_oe_n ##1 !st_q.rdy))
    else $error("sense output active during overcurrent window");

  a_sense_fs_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (failsafe || !vdd_s) |-> sense_out_oe_n)
    else $error("sensing active in fail-safe or without supply");

  a_hold_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    (st_q.global_config_reg[GCR_TH_EN] && !st_q.chan[sel_ch] && $stable(st_q.global_config_reg))
    |=> $stable(sense_out))
    else $error("held sense value changed while channel off");

  a_rdy_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (st_q.chan[sel_ch] && !st_d.chan[sel_ch]) |=> sense_rdy_n_oe_n)
    else $error("sense ready not released at turn-off");

  a_fault_flag: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ov_evt || uv_evt || chan_flt[0].oc || chan_flt[1].ot) |=> !fault_flag_n_oe_n)
    else $error("fault flag not asserted after fault");

  a_regs_reset: assert property (
    @(posedge clk) disable iff (sys_rst)
    !rst_s ##1 !rst_s |-> (st_q.global_config_reg == GCR_RST && st_q.ctl0 == CTL_RST))
    else $error("registers not held at reset value");

  a_wd_fail: assert property (
    @(posedge clk) disable iff (sys_rst)
    (st_q.mode == SSC_NORMAL && rst_s && st_q.rst_p && !word_done
     && st_q.wd_cnt == ALIVE_CYC - 1'b1) |=> failsafe)
    else $error("watchdog timeout did not enter fail-safe");

  a_so_tristate: assert property (
    @(posedge clk) disable iff (sys_rst)
    cs_s |-> (so_oe_n && !sclk_rise && !sclk_fall))
    else $error("serial port active while deselected");

  a_wake_normal: assert property (
    @(posedge clk) disable iff (sys_rst)
    (asleep && din_rise) |=> (st_q.mode == SSC_NORMAL && st_q.global_config_reg == GCR_RST))
    else $error("direct input rise did not wake the device");

endmodule : ssc_front_end

// File: ssc_front_end_tb.sv
`timescale 1ns/100ps
module ssc_front_end_tb;
  import ssc_pkg::*;
  localparam logic [23:0] ALIVE  = 24'h000258;
  localparam logic [23:0] SLP    = 24'h000064;
  localparam logic [23:0] LOSS   = 24'h000032;
  localparam logic [7:0]  SETTLE = 8'h08;

  logic               clk, sys_rst, sclk, chip_sel_n, si, so_out, so_oe_n, so_w;
  logic               reset_n_in, vdd_ok, pwm_clk, pwm_run, ov_evt, uv_evt, alive;
  logic [1:0]         din, load_type_sel, oc_window, chan_on, load_motor;
  ssc_flt_s [1:0]     chan_flt;
  logic [SENSE_W-1:0] sense_in, sense_out;
  logic               sense_out_oe_n, sense_rdy_n_out, sense_rdy_n_oe_n;
  logic               fault_flag_n_out, fault_flag_n_oe_n, asleep, failsafe;
  logic [15:0]        rdata;
  int                 err_count, n_tests;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  always begin
    repeat (10) @(negedge clk);
    if (pwm_run) pwm_clk = ~pwm_clk;
  end

  assign so_w = so_oe_n ? 1'bz : so_out;

  ssc_front_end #(.ALIVE_CYC(ALIVE), .SLEEP_CYC(SLP), .LOSS_CYC(LOSS),
    .SETTLE_CYC(SETTLE)) i_dut (.clk, .sys_rst, .sclk, .chip_sel_n, .si,
    .so_out, .so_oe_n, .reset_n_in, .din, .load_type_sel, .vdd_ok, .pwm_clk,
    .chan_flt, .ov_evt, .uv_evt, .oc_window, .sense_in, .sense_out,
    .sense_out_oe_n, .sense_rdy_n_out, .sense_rdy_n_oe_n, .fault_flag_n_out,
    .fault_flag_n_oe_n, .chan_on, .load_motor, .asleep, .failsafe);

  ssc_spi_mst i_mst (.clk, .sclk, .cs_n(chip_sel_n), .si, .so(so_w));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic sx(input logic [3:0] a, input logic [8:0] d);
    alive = ~alive;
    i_mst.xfer({alive, 2'b00, a, d}, rdata);
  endtask : sx

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic t_reset;
    chk("asleep", 1, asleep);
    chk("chan_on", 0, chan_on);
    chk("fault_oe_n", 1, fault_flag_n_oe_n);
    chk("so_oe_n", 1, so_oe_n);
    chk("rdy_out", 0, sense_rdy_n_out);
    chk("fault_out", 0, fault_flag_n_out);
    $display("test reset done");
  endtask : t_reset

  task automatic t_wake;
    reset_n_in = 1'b1;
    cyc(6);
    chk("asleep", 0, asleep);
    chk("failsafe", 0, failsafe);
    $display("test wake done");
  endtask : t_wake

  task automatic t_load;
    for (int v = 0; v < 4; v++) begin
      load_type_sel = v[1:0];
      cyc(4);
      chk("load_motor", v[1:0], load_motor);
    end
    $display("test load_type done");
  endtask : t_load

  task automatic t_din;
    din = 2'b10;
    cyc(5);
    chk("chan_on", 2'b10, chan_on);
    din = 2'b00;
    cyc(5);
    chk("chan_on", 0, chan_on);
    $display("test direct done");
  endtask : t_din

  task automatic t_regs;
    sx(ADDR_CTL0, 9'h003);
    chk("chan_on", 2'b01, chan_on);
    sx(4'h0, 9'h000);
    chk("ctl0_read", 2'b11, rdata[1:0]);
    sx(4'h0, 9'h000);
    chk("status", 4'b0110, rdata[7:4]);
    sx(ADDR_CTL0, 9'h000);
    chk("chan_on", 0, chan_on);
    chk("so_oe_n", 1, so_oe_n);
    $display("test registers done");
  endtask : t_regs

  task automatic t_fault;
    sx(ADDR_GCR, 9'h008);
    ov_evt = 1'b1;
    cyc(2);
    ov_evt = 1'b0;
    cyc(4);
    chk("fault_oe_n", 0, fault_flag_n_oe_n);
    pwm_run = 1'b0;
    cyc(80);
    pwm_run = 1'b1;
    cyc(30);
    sx(4'h0, 9'h000);
    sx(4'h0, 9'h000);
    chk("status_flt", 3'b101, rdata[2:0]);
    chk("fault_oe_n", 1, fault_flag_n_oe_n);
    $display("test fault done");
  endtask : t_fault

  task automatic t_sense;
    sx(ADDR_GCR, 9'h001);
    chk("sense_oe_n", 0, sense_out_oe_n);
    oc_window = 2'b01;
    cyc(3);
    chk("sense_oe_n", 1, sense_out_oe_n);
    oc_window = 2'b00;
    vdd_ok = 1'b0;
    cyc(5);
    chk("sense_oe_n", 1, sense_out_oe_n);
    vdd_ok = 1'b1;
    sense_in = 10'h2A5;
    sx(ADDR_GCR, 9'h005);
    sx(ADDR_CTL0, 9'h003);
    cyc(12);
    chk("rdy_oe_n", 0, sense_rdy_n_oe_n);
    sx(ADDR_CTL0, 9'h000);
    chk("rdy_oe_n", 1, sense_rdy_n_oe_n);
    sense_in = 10'h15A;
    cyc(4);
    chk("sense_out", 10'h2A5, sense_out);
    sx(ADDR_GCR, 9'h000);
    chk("sense_oe_n", 1, sense_out_oe_n);
    $display("test sense done");
  endtask : t_sense

  task automatic t_wdog;
    cyc(500);
    chk("failsafe", 0, failsafe);
    cyc(200);
    chk("failsafe", 1, failsafe);
    reset_n_in = 1'b0;
    cyc(4);
    sx(ADDR_CTL0, 9'h003);
    chk("chan_on", 0, chan_on);
    reset_n_in = 1'b1;
    cyc(6);
    chk("failsafe", 0, failsafe);
    $display("test watchdog done");
  endtask : t_wdog

  task automatic t_sleep;
    reset_n_in = 1'b0;
    cyc(60);
    chk("asleep", 0, asleep);
    cyc(60);
    chk("asleep", 1, asleep);
    din = 2'b01;
    cyc(5);
    chk("asleep", 0, asleep);
    chk("chan_on", 2'b01, chan_on);
    din = 2'b00;
    $display("test sleep done");
  endtask : t_sleep

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    reset_n_in = 1'b0;
    din = 2'b00;
    load_type_sel = 2'b11;
    vdd_ok = 1'b1;
    pwm_clk = 1'b0;
    pwm_run = 1'b1;
    chan_flt = '0;
    ov_evt = 1'b0;
    uv_evt = 1'b0;
    oc_window = 2'b00;
    sense_in = '0;
    alive = 1'b0;
    err_count = 0;
    n_tests = 0;
    cyc(6);
    sys_rst = 1'b0;
    cyc(4);
    t_reset();
    t_wake();
    t_load();
    t_din();
    t_regs();
    t_fault();
    t_sense();
    t_wdog();
    t_sleep();
    wrap_up();
  end
endmodule : ssc_front_end_tb

// File: ssc_pkg.sv
package ssc_pkg;

  // Serial word layout
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ALIVE_BIT    = 15;
  localparam int unsigned ADDR_LSB     = 9;
  localparam int unsigned ADDR_MSB     = 12;
  localparam logic [4:0]  WORD_BITS    = 5'h10;

  // Write addresses (serial-input registers)
  localparam logic [3:0]  ADDR_GCR     = 4'h5;
  localparam logic [3:0]  ADDR_CTL0    = 4'h6;
  localparam logic [3:0]  ADDR_CTL1    = 4'h7;

  // Readback selectors (one of 8 internal registers)
  localparam logic [2:0]  RD_STAT      = 3'h0;
  localparam logic [2:0]  RD_FLT0      = 3'h1;
  localparam logic [2:0]  RD_FLT1      = 3'h2;
  localparam logic [2:0]  RD_DIAG0     = 3'h3;
  localparam logic [2:0]  RD_DIAG1     = 3'h4;
  localparam logic [2:0]  RD_GCR       = 3'h5;
  localparam logic [2:0]  RD_CTL0      = 3'h6;
  localparam logic [2:0]  RD_CTL1      = 3'h7;

  // global_config_reg fields
  localparam int unsigned GCR_SENSE_A  = 0;
  localparam int unsigned GCR_SENSE_B  = 1;
  localparam int unsigned GCR_TH_EN    = 2;
  localparam int unsigned GCR_EXT_CLK  = 3;
  localparam logic [15:0] GCR_RST      = 16'h0000;

  // Channel control register fields
  localparam int unsigned CTL_ON       = 0;
  localparam int unsigned CTL_DIR_DIS  = 1;
  localparam logic [15:0] CTL_RST      = 16'h0000;

  // Sensed value width
  localparam int unsigned SENSE_W      = 10;

  // Timing counts in clk cycles (20 MHz)
  localparam int unsigned CNT_W        = 24;
  localparam logic [23:0] ALIVE_TIMEOUT_CYC = 24'h004E20;
  localparam logic [23:0] SLEEP_DLY_CYC     = 24'h000FA0;
  localparam logic [23:0] CLK_LOSS_CYC      = 24'h0007D0;
  localparam logic [7:0]  SENSE_SETTLE_CYC  = 8'h28;

  typedef enum logic [2:0] {
    SSC_SLEEP    = 3'b001,
    SSC_NORMAL   = 3'b010,
    SSC_FAILSAFE = 3'b100
  } ssc_mode_e;

  // Per-channel fault events from the analog side
  typedef struct packed {
    logic oc;
    logic ot;
    logic short_vpwr;
    logic severe_sc;
    logic open_load_on;
    logic open_load_off;
  } ssc_flt_s;

endpackage : ssc_pkg

// File: ssc_spi_mst.sv
`timescale 1ns/100ps
module ssc_spi_mst (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap

  // Called just after a falling clk edge
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    gap(8);
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      gap(2);
      sclk = 1'b1;
      gap(4);
      r[i] = so;
      sclk = 1'b0;
      // Hold si past the fall, both pins share one synchroniser delay
      gap(2);
    end
    gap(4);
    cs_n = 1'b1;
    si   = ~w[0];
    gap(6);
  endtask : xfer
endmodule : ssc_spi_mst

// File: ssc_sync.sv
`timescale 1ns/100ps
module ssc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssc_sync_s;

  ssc_sync_s st_q;
  ssc_sync_s st_d;

  always_comb begin
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : ssc_sync
